// file: design/mgmt_irq_status_enable.sv
/*
  Management interrupt group: W1C event status, live source status,
  enables, group interrupt and its three routed destinations, reached
  over an AXI4-Lite slave.
  Assumes aresetn is the standby-power reset; source interrupt inputs
  come from logic on aclk, general-purpose and fan pins are async.
*/
// Added by the designer: the AXI4-Lite interface to the registers.
// Overview of operation
// - Status 3 at 0x12 latches events of inputs 20-22,24-26,60; bit 3 reserved.
// - Status 4 at 0x13 latches events of inputs 30-33,41-43,61 in bits 0-7.
// - Status 5 at 0x14 latches inputs 54-57 and fan inputs 1,2; bits 4,5 reserved.
// - Writing one to a status 3/4/5 bit clears it.
// - Location 0x15 always reads zero.
// - An enable bit of one passes its source to the group; zero blocks it.
// - Enable 1 at 0x16 enables parallel, UART B, UART A, floppy, MIDI.
// - Enable 2 at 0x17 enables mouse, keyboard, infrared and port-12 sources.
// - Group interrupt goes to pin, serial stream, wake logic, each enabled alone.
// - Enable 2 bit 5 forwards the group into the wake logic.
// - Enable 2 bit 6 places the group onto the serial interrupt stream.
// - Enable 2 bit 7 drives the group onto the active-low output pin.
// - Enable 3 at 0x18 matches status 3 layout; bit 3 reserved.
// - Status 1 bits 1-5 follow their sources; writes do not clear them.
// - Infrared status bit sets on receive transition, clears on status 2 read.
`default_nettype none
module mgmt_irq_status_enable #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic parport_irq_status,
  input wire logic uart_b_irq_status,
  input wire logic uart_a_irq_status,
  input wire logic floppy_irq_status,
  input wire logic midi_irq_status,
  input wire logic mouse_irq_status,
  input wire logic keyboard_irq_status,
  input wire logic port12_irq_status,
  input wire logic infrared_rx_pin,
  input wire logic [7:0] gen_io_set_3,
  input wire logic [7:0] gen_io_set_4,
  input wire logic [3:0] gen_io_set_5,
  input wire logic fan_speed_in_1,
  input wire logic fan_speed_in_2,
  output logic irq,
  output logic group_mgmt_irq_n,
  output logic mgmt_irq_out_pin_n,
  output logic serial_irq_req,
  output logic power_mgmt_event_req
);
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_addr_check
    $error("ADDR_W must be between 10 and 32");
  end

  logic [mgmt_irq_pkg::NUM_PINS-1:0] pins;
  logic [mgmt_irq_pkg::NUM_PINS-1:0] sync1_q;
  logic [mgmt_irq_pkg::NUM_PINS-1:0] sync2_q;
  logic [mgmt_irq_pkg::NUM_PINS-1:0] prev_q;
  logic [mgmt_irq_pkg::NUM_PINS-1:0] rise;
  logic ir_toggle;

  assign pins = {infrared_rx_pin, fan_speed_in_2, fan_speed_in_1, 2'h0,
                 gen_io_set_5, gen_io_set_4, gen_io_set_3};

  // Two-stage synchroniser, then a third stage for edge detection
  for (genvar i = 0; i < mgmt_irq_pkg::NUM_PINS; i++) begin : g_pin
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
        prev_q[i] <= 1'b0;
      end else begin
        sync1_q[i] <= pins[i];
        sync2_q[i] <= sync1_q[i];
        prev_q[i] <= sync2_q[i];
      end
    end
    assign rise[i] = sync2_q[i] & ~prev_q[i];
  end

  // Either edge on the selected infrared receive line counts
  assign ir_toggle = sync2_q[mgmt_irq_pkg::PIN_IR] ^ prev_q[mgmt_irq_pkg::PIN_IR];

  logic [7:0] set_3;
  logic [7:0] set_4;
  logic [7:0] set_5;
  assign set_3 = rise[7:0] & mgmt_irq_pkg::MASK_STATUS_3;
  assign set_4 = rise[15:8] & mgmt_irq_pkg::MASK_STATUS_4;
  assign set_5 = rise[23:16] & mgmt_irq_pkg::MASK_STATUS_5;

  // AXI4-Lite write side: address and data taken in either order
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic do_write;
  logic wr_ok;
  logic wr_en;
  logic [7:0] wr_idx;

  assign awready = ~aw_held_q & ~bvalid_q;
  assign wready = ~w_held_q & ~bvalid_q;
  assign do_write = aw_held_q & w_held_q & ~bvalid_q;
  assign wr_idx = aw_addr_q[9:2];
  assign wr_ok = (aw_addr_q[1:0] == 2'h0) && ((aw_addr_q >> 10) == '0)
                 && (wr_idx >= mgmt_irq_pkg::IDX_STATUS_1)
                 && (wr_idx <= mgmt_irq_pkg::IDX_ENABLE_3);
  // Registers are one byte wide, so only lane 0 carries a write
  assign wr_en = do_write & wr_ok & w_lane0_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane0_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_held_q <= 1'b1;
      w_data_q <= wdata[7:0];
      w_lane0_q <= wstrb[0];
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= mgmt_irq_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? mgmt_irq_pkg::RESP_OKAY : mgmt_irq_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  logic [7:0] clr_3;
  logic [7:0] clr_4;
  logic [7:0] clr_5;
  assign clr_3 = (wr_en && wr_idx == mgmt_irq_pkg::IDX_STATUS_3) ? w_data_q : 8'h00;
  assign clr_4 = (wr_en && wr_idx == mgmt_irq_pkg::IDX_STATUS_4) ? w_data_q : 8'h00;
  assign clr_5 = (wr_en && wr_idx == mgmt_irq_pkg::IDX_STATUS_5) ? w_data_q : 8'h00;

  logic [7:0] status_3_q;
  logic [7:0] status_4_q;
  logic [7:0] status_5_q;
  // A new event in the clearing cycle survives the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_3_q <= mgmt_irq_pkg::REG_RESET;
      status_4_q <= mgmt_irq_pkg::REG_RESET;
      status_5_q <= mgmt_irq_pkg::REG_RESET;
    end else begin
      status_3_q <= (status_3_q & ~clr_3) | set_3;
      status_4_q <= (status_4_q & ~clr_4) | set_4;
      status_5_q <= (status_5_q & ~clr_5) | set_5;
    end
  end

  logic [7:0] enable_1_q;
  logic [7:0] enable_2_q;
  logic [7:0] enable_3_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_1_q <= mgmt_irq_pkg::REG_RESET;
      enable_2_q <= mgmt_irq_pkg::REG_RESET;
      enable_3_q <= mgmt_irq_pkg::REG_RESET;
    end else if (wr_en) begin
      if (wr_idx == mgmt_irq_pkg::IDX_ENABLE_1) begin
        enable_1_q <= w_data_q & mgmt_irq_pkg::MASK_ENABLE_1;
      end
      if (wr_idx == mgmt_irq_pkg::IDX_ENABLE_2) begin
        enable_2_q <= w_data_q & mgmt_irq_pkg::MASK_ENABLE_2;
      end
      if (wr_idx == mgmt_irq_pkg::IDX_ENABLE_3) begin
        enable_3_q <= w_data_q & mgmt_irq_pkg::MASK_ENABLE_3;
      end
    end
  end

  // AXI4-Lite read side
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic ar_hs;
  logic rd_ok;
  logic [7:0] rd_idx;
  logic [7:0] rd_byte;
  logic ir_clear;

  assign arready = ~rvalid_q;
  assign ar_hs = arvalid & arready;
  assign rd_idx = araddr[9:2];
  assign rd_ok = (araddr[1:0] == 2'h0) && ((araddr >> 10) == '0)
                 && (rd_idx >= mgmt_irq_pkg::IDX_STATUS_1)
                 && (rd_idx <= mgmt_irq_pkg::IDX_ENABLE_3);
  assign ir_clear = ar_hs & rd_ok & (rd_idx == mgmt_irq_pkg::IDX_STATUS_2);
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  logic ir_status_q;
  // Read-to-clear; an edge in the read cycle keeps the bit set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ir_status_q <= 1'b0;
    end else if (ir_toggle) begin
      ir_status_q <= 1'b1;
    end else if (ir_clear) begin
      ir_status_q <= 1'b0;
    end
  end

  logic [7:0] status_1;
  logic [7:0] status_2;
  // Live view: these clear only at their sources, except the status 2 infrared bit, which clears on read
  assign status_1 = {2'h0, midi_irq_status, floppy_irq_status, uart_a_irq_status,
                     uart_b_irq_status, parport_irq_status, 1'b0};
  assign status_2 = {3'h0, port12_irq_status, 1'b0, ir_status_q,
                     keyboard_irq_status, mouse_irq_status};

  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      mgmt_irq_pkg::IDX_STATUS_1: rd_byte = status_1;
      mgmt_irq_pkg::IDX_STATUS_2: rd_byte = status_2;
      mgmt_irq_pkg::IDX_STATUS_3: rd_byte = status_3_q;
      mgmt_irq_pkg::IDX_STATUS_4: rd_byte = status_4_q;
      mgmt_irq_pkg::IDX_STATUS_5: rd_byte = status_5_q;
      mgmt_irq_pkg::IDX_ENABLE_1: rd_byte = enable_1_q;
      mgmt_irq_pkg::IDX_ENABLE_2: rd_byte = enable_2_q;
      mgmt_irq_pkg::IDX_ENABLE_3: rd_byte = enable_3_q;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= mgmt_irq_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_ok ? rd_byte : 8'h00};
      rresp_q <= rd_ok ? mgmt_irq_pkg::RESP_OKAY : mgmt_irq_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Group combine; status 4 and 5 have no enables and do not feed the group
  logic [7:0] src_1;
  logic [7:0] src_2;
  logic [7:0] src_3;
  logic group;
  assign src_1 = status_1 & enable_1_q;
  assign src_2 = status_2 & enable_2_q & mgmt_irq_pkg::MASK_EN2_SOURCES;
  assign src_3 = status_3_q & enable_3_q;
  assign group = |{src_1, src_2, src_3};

  logic group_q;
  logic pin_n_q;
  logic serial_q;
  logic wake_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      group_q <= 1'b0;
      pin_n_q <= 1'b1;
      serial_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      group_q <= group;
      pin_n_q <= ~(group & enable_2_q[mgmt_irq_pkg::EN2_PIN_BIT]);
      serial_q <= group & enable_2_q[mgmt_irq_pkg::EN2_SERIAL_BIT];
      wake_q <= group & enable_2_q[mgmt_irq_pkg::EN2_WAKE_BIT];
    end
  end
  assign irq = group_q;
  assign group_mgmt_irq_n = ~group_q;
  assign mgmt_irq_out_pin_n = pin_n_q;
  assign serial_irq_req = serial_q;
  assign power_mgmt_event_req = wake_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_set_wins_clear: assert property (set_3 != 8'h00 |=>
      (status_3_q & $past(set_3)) == $past(set_3))
    else $error("status 3 event lost");
  a_gp30_event: assert property (rise[8] |=> status_4_q[0])
    else $error("status 4 bit 0 not set by event");
  a_fan2_event: assert property (rise[23] |=> status_5_q[7])
    else $error("fan input 2 event not latched");
  a_w1c_clears: assert property (|clr_3 |=>
      (status_3_q & $past(clr_3) & ~$past(set_3)) == 8'h00)
    else $error("write one did not clear status 3");
  a_w0_keeps: assert property (wr_en && wr_idx == mgmt_irq_pkg::IDX_STATUS_4 |=>
      (status_4_q & $past(status_4_q) & ~$past(w_data_q))
      == ($past(status_4_q) & ~$past(w_data_q)))
    else $error("write zero disturbed status 4");
  a_hole_reads_zero: assert property (
      ar_hs && araddr == ADDR_W'(4 * mgmt_irq_pkg::IDX_HOLE_15) |=>
      rvalid && rdata == 32'h0000_0000 && rresp == mgmt_irq_pkg::RESP_OKAY)
    else $error("reserved hole read not zero");
  a_reserved_zero: assert property (
      (enable_1_q & ~mgmt_irq_pkg::MASK_ENABLE_1) == 8'h00
      && !enable_2_q[3] && !enable_3_q[3] && !status_3_q[3])
    else $error("reserved bit set");
  a_enabled_src_irq: assert property ((status_3_q & enable_3_q) != 8'h00
      |=> !group_mgmt_irq_n && irq)
    else $error("enabled source missed group");
  a_group_is_or: assert property (##1 irq == $past(group))
    else $error("group is not OR of enabled sources");
  a_pin_route: assert property (##1 mgmt_irq_out_pin_n ==
      !($past(group) && $past(enable_2_q[7])))
    else $error("pin route wrong");
  a_serial_route: assert property (##1 serial_irq_req ==
      ($past(group) && $past(enable_2_q[6])))
    else $error("serial route wrong");
  a_wake_route: assert property (##1 power_mgmt_event_req ==
      ($past(group) && $past(enable_2_q[5])))
    else $error("wake route wrong");
  a_ir_read_clear: assert property (ir_clear && !ir_toggle |=> !ir_status_q)
    else $error("infrared status not cleared by read");
  a_status1_live: assert property (
      ar_hs && rd_ok && rd_idx == mgmt_irq_pkg::IDX_STATUS_1 |=>
      rdata[5:1] == $past({midi_irq_status, floppy_irq_status, uart_a_irq_status,
                          uart_b_irq_status, parport_irq_status}))
    else $error("status 1 does not follow sources");
  a_reset_zero: assert property (disable iff (1'b0) !aresetn |=>
      status_3_q == 8'h00 && status_5_q == 8'h00 && enable_2_q == 8'h00)
    else $error("registers not zero after reset");

  c_w1c_write: cover property (|clr_3 ##1 status_3_q == 8'h00);
  c_ir_cleared: cover property (ir_status_q ##1 ir_clear ##1 !ir_status_q);
  c_pin_low: cover property (!mgmt_irq_out_pin_n);
  c_both_routes: cover property (serial_irq_req && power_mgmt_event_req);
endmodule : mgmt_irq_status_enable
`default_nettype wire

// file: design/mgmt_irq_pkg.sv
/*
  Register indices, field masks and bus answers of the management
  interrupt status and enable block.
  Assumes byte address = 4 * index on a 32-bit register bus.
*/
`default_nettype none
package mgmt_irq_pkg;
  localparam int REG_W = 8;
  localparam logic [7:0] IDX_STATUS_1 = 8'h10;
  localparam logic [7:0] IDX_STATUS_2 = 8'h11;
  localparam logic [7:0] IDX_STATUS_3 = 8'h12;
  localparam logic [7:0] IDX_STATUS_4 = 8'h13;
  localparam logic [7:0] IDX_STATUS_5 = 8'h14;
  localparam logic [7:0] IDX_HOLE_15 = 8'h15;
  localparam logic [7:0] IDX_ENABLE_1 = 8'h16;
  localparam logic [7:0] IDX_ENABLE_2 = 8'h17;
  localparam logic [7:0] IDX_ENABLE_3 = 8'h18;
  localparam logic [7:0] MASK_STATUS_1 = 8'h3E;
  localparam logic [7:0] MASK_STATUS_2 = 8'h17;
  localparam logic [7:0] MASK_STATUS_3 = 8'hF7;
  localparam logic [7:0] MASK_STATUS_4 = 8'hFF;
  localparam logic [7:0] MASK_STATUS_5 = 8'hCF;
  localparam logic [7:0] MASK_ENABLE_1 = 8'h3E;
  localparam logic [7:0] MASK_ENABLE_2 = 8'hF7;
  localparam logic [7:0] MASK_ENABLE_3 = 8'hF7;
  localparam logic [7:0] MASK_EN2_SOURCES = 8'h17;
  localparam int EN2_WAKE_BIT = 5;
  localparam int EN2_SERIAL_BIT = 6;
  localparam int EN2_PIN_BIT = 7;
  localparam int STATUS_2_IR_BIT = 2;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int NUM_PINS = 25;
  localparam int PIN_STATUS_4_BASE = 8;
  localparam int PIN_STATUS_5_BASE = 16;
  localparam int PIN_IR = 24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : mgmt_irq_pkg
`default_nettype wire

// file: tb/tb_mgmt_irq_status_enable.sv
/*
  Self-checking bench of the management interrupt status and enable block.
  Assumes the design package and module are compiled first; single clock domain.
*/
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_mgmt_irq_status_enable;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ADDR_W = 12;
  int err_total = 0;
  int compares = 0;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic par_s = 1'b0, ub_s = 1'b0, ua_s = 1'b0, fl_s = 1'b0, midi_s = 1'b0;
  logic mouse_s = 1'b0, kbd_s = 1'b0, p12_s = 1'b0, ir_pin = 1'b0;
  logic [7:0] gp3 = 8'h0, gp4 = 8'h0;
  logic [3:0] gp5 = 4'h0;
  logic fan1 = 1'b0, fan2 = 1'b0;
  logic irq, group_n, pin_n, serial_req, wake_req;

  always #2.5 aclk = ~aclk;

  mgmt_irq_status_enable #(.ADDR_W(ADDR_W)) mgmt_irq_status_enable_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .parport_irq_status(par_s), .uart_b_irq_status(ub_s),
    .uart_a_irq_status(ua_s), .floppy_irq_status(fl_s), .midi_irq_status(midi_s),
    .mouse_irq_status(mouse_s), .keyboard_irq_status(kbd_s), .port12_irq_status(p12_s),
    .infrared_rx_pin(ir_pin), .gen_io_set_3(gp3), .gen_io_set_4(gp4), .gen_io_set_5(gp5),
    .fan_speed_in_1(fan1), .fan_speed_in_2(fan2), .irq(irq), .group_mgmt_irq_n(group_n),
    .mgmt_irq_out_pin_n(pin_n), .serial_irq_req(serial_req),
    .power_mgmt_event_req(wake_req)
  );

  task automatic conclude();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // Handshakes are judged at the rising edge itself; only the watchdog ends a wait
  task automatic wr(input logic [7:0] idx, input logic [7:0] data, output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, data};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [31:0] data, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic ewr(input logic [7:0] idx, input logic [7:0] data);
    logic [1:0] r;
    wr(idx, data, r);
    `CHK(r, mgmt_irq_pkg::RESP_OKAY)
  endtask : ewr

  task automatic erd(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    `CHK(d, {24'h0, exp})
    `CHK(r, mgmt_irq_pkg::RESP_OKAY)
  endtask : erd

  // Covers the two synchroniser stages plus the registered group outputs
  task automatic settle();
    repeat (6) @(posedge aclk);
    @(negedge aclk);
  endtask : settle

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    `CHK({irq, group_n, pin_n, serial_req, wake_req}, 5'h0C)
    for (int i = 8'h12; i <= 8'h18; i++) erd(8'(i), 8'h00);
    rd(8'h30, d, r);
    `CHK({r, d}, {mgmt_irq_pkg::RESP_SLVERR, 32'h0})
    wr(8'h30, 8'hFF, r);
    `CHK(r, mgmt_irq_pkg::RESP_SLVERR)
  endtask : t_reset

  task automatic t_enables();
    ewr(mgmt_irq_pkg::IDX_ENABLE_1, 8'hFF);
    ewr(mgmt_irq_pkg::IDX_ENABLE_2, 8'hFF);
    ewr(mgmt_irq_pkg::IDX_ENABLE_3, 8'hFF);
    ewr(mgmt_irq_pkg::IDX_HOLE_15, 8'hFF);
    erd(mgmt_irq_pkg::IDX_ENABLE_1, 8'h3E);
    erd(mgmt_irq_pkg::IDX_ENABLE_2, 8'hF7);
    erd(mgmt_irq_pkg::IDX_ENABLE_3, 8'hF7);
    erd(mgmt_irq_pkg::IDX_HOLE_15, 8'h00);
    for (int i = 8'h16; i <= 8'h18; i++) ewr(8'(i), 8'h00);
  endtask : t_enables

  task automatic t_events();
    @(posedge aclk);
    {gp3, gp4, gp5, fan1, fan2} <= {8'hFF, 8'hFF, 4'hF, 2'h3};
    settle();
    @(posedge aclk) {gp3, gp4, gp5, fan1, fan2} <= 22'h0;
    erd(mgmt_irq_pkg::IDX_STATUS_3, 8'hF7);
    erd(mgmt_irq_pkg::IDX_STATUS_4, 8'hFF);
    erd(mgmt_irq_pkg::IDX_STATUS_5, 8'hCF);
    ewr(mgmt_irq_pkg::IDX_STATUS_3, 8'h00);
    erd(mgmt_irq_pkg::IDX_STATUS_3, 8'hF7);
    ewr(mgmt_irq_pkg::IDX_STATUS_3, 8'h01);
    ewr(mgmt_irq_pkg::IDX_STATUS_4, 8'h80);
    ewr(mgmt_irq_pkg::IDX_STATUS_5, 8'hC0);
    erd(mgmt_irq_pkg::IDX_STATUS_3, 8'hF6);
    erd(mgmt_irq_pkg::IDX_STATUS_4, 8'h7F);
    erd(mgmt_irq_pkg::IDX_STATUS_5, 8'h0F);
  endtask : t_events

  task automatic t_group();
    settle();
    `CHK(irq, 1'b0)
    ewr(mgmt_irq_pkg::IDX_ENABLE_3, 8'h80);
    settle();
    `CHK({irq, group_n, pin_n, serial_req, wake_req}, 5'h14)
    for (int b = 5; b <= 7; b++) begin
      ewr(mgmt_irq_pkg::IDX_ENABLE_2, 8'(1 << b));
      settle();
      `CHK(wake_req, 1'(b == 5))
      `CHK(serial_req, 1'(b == 6))
      `CHK(pin_n, 1'(b != 7))
    end
    ewr(mgmt_irq_pkg::IDX_STATUS_3, 8'hF6);
    settle();
    `CHK({irq, pin_n}, 2'h1)
    ewr(mgmt_irq_pkg::IDX_ENABLE_3, 8'h00);
  endtask : t_group

  task automatic t_sources();
    @(posedge aclk);
    {par_s, ub_s, ua_s, fl_s, midi_s, mouse_s, kbd_s, p12_s} <= 8'hFF;
    settle();
    erd(mgmt_irq_pkg::IDX_STATUS_1, 8'h3E);
    erd(mgmt_irq_pkg::IDX_STATUS_2, 8'h13);
    ewr(mgmt_irq_pkg::IDX_STATUS_1, 8'hFF);
    erd(mgmt_irq_pkg::IDX_STATUS_1, 8'h3E);
    ewr(mgmt_irq_pkg::IDX_ENABLE_1, 8'h02);
    settle();
    `CHK(irq, 1'b1)
    @(posedge aclk) par_s <= 1'b0;
    settle();
    `CHK(irq, 1'b0)
    @(posedge aclk) {ub_s, ua_s, fl_s, midi_s, mouse_s, kbd_s, p12_s} <= 7'h00;
    ewr(mgmt_irq_pkg::IDX_ENABLE_1, 8'h00);
    erd(mgmt_irq_pkg::IDX_STATUS_1, 8'h00);
  endtask : t_sources

  task automatic t_infrared();
    @(posedge aclk);
    ir_pin <= 1'b1;
    ewr(mgmt_irq_pkg::IDX_ENABLE_2, 8'h04);
    settle();
    `CHK(irq, 1'b1)
    erd(mgmt_irq_pkg::IDX_STATUS_2, 8'h04);
    erd(mgmt_irq_pkg::IDX_STATUS_2, 8'h00);
    settle();
    `CHK(irq, 1'b0)
    @(posedge aclk) ir_pin <= 1'b0;
    settle();
    erd(mgmt_irq_pkg::IDX_STATUS_2, 8'h04);
  endtask : t_infrared

  // Reset in mid-run with the pin route active must drop every route
  task automatic t_midreset();
    par_s <= 1'b1;
    ewr(mgmt_irq_pkg::IDX_ENABLE_1, 8'h02);
    ewr(mgmt_irq_pkg::IDX_ENABLE_2, 8'h80);
    settle();
    `CHK(pin_n, 1'b0)
    @(posedge aclk);
    aresetn <= 1'b0;
    par_s <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK({irq, group_n, pin_n, serial_req, wake_req}, 5'h0C)
    erd(mgmt_irq_pkg::IDX_ENABLE_1, 8'h00);
    erd(mgmt_irq_pkg::IDX_ENABLE_2, 8'h00);
  endtask : t_midreset

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_enables();
    t_events();
    t_group();
    t_sources();
    t_infrared();
    t_midreset();
    conclude();
  end

  // The whole sequence takes a few hundred cycles; this is far beyond it
  initial begin
    #200us;
    err_total++;
    conclude();
  end
endmodule : tb_mgmt_irq_status_enable
`undef CHK
`default_nettype wire
